// file: pkg/lpm_pkg.sv
// Package for the low-power mode controller
package lpm_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] LPM_OFF_CTRL    = 8'h00;
    localparam logic [7:0] LPM_OFF_STATUS  = 8'h04;
    localparam logic [7:0] LPM_OFF_IRQ_STS = 8'h08;
    localparam logic [7:0] LPM_OFF_IRQ_MSK = 8'h0C;
    localparam logic [7:0] LPM_OFF_MBOX    = 8'h10;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         LPM_CTRL_REQ_BIT  = 0;
    localparam int         LPM_CTRL_CTSP_BIT = 4;
    localparam int         LPM_CTRL_MODE_LSB = 1;
    localparam logic [2:0] LPM_MODE_RST      = 3'h1;
    localparam logic [4:0] LPM_CTRL_RST      = 5'h02;
    localparam logic [2:0] LPM_IRQ_RST       = 3'h0;
    localparam logic [31:0] LPM_MBOX_SUSPEND = 32'h0000_0001;
    localparam int         LPM_IRQ_WAKE      = 0;
    localparam int         LPM_IRQ_ENTER     = 1;
    localparam int         LPM_IRQ_LOCK      = 2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int LPM_CLK_MHZ      = 40;
    localparam int LPM_LOCK_US      = 50;
    localparam int LPM_LOCK_CYC_MAX = LPM_LOCK_US * LPM_CLK_MHZ;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        LPM_NORMAL   = 3'b000,
        LPM_DRAIN    = 3'b001,
        LPM_SUSPEND  = 3'b010,
        LPM_RELOCK   = 3'b011,
        LPM_LOWPOWER = 3'b100
    } lpm_state_t;

    typedef struct packed {
        logic dp;
        logic dm;
        logic otg_id;
        logic ssrx_resume;
        logic vbus;
        logic uart_cts;
        logic ctl0;
    } lpm_wake_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic pll_en;
        logic phy_u3;
        logic io_hold;
        logic mem_retain;
        logic pc_hold;
    } lpm_pwr_t;

endpackage

// file: logic/lpm_ctrl.sv
// Low-power mode controller with AHB-Lite register slave
//
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/10ps

// Notes on behaviour
// - Normal mode keeps processor clock and all PLLs running.
// - Four low-power states, codes one to four, selectable by software.
// - In suspend_phy_on the PHY stays in U3; everything else is off.
// - I/O pins hold level and direction while suspended.
// - Configuration registers, buffer and RAM contents kept while suspended.
// - Entry waits until no bus or data transaction is pending.
// - Non-reset wake keeps the program counter; only reset pin restarts it.
// - Firmware may request suspend through the control register.
// - Exit on line, ID, SS resume, VBUS, CTS level, control line 0, reset.
module lpm_ctrl #(
    parameter int LOCK_CYC = lpm_pkg::LPM_LOCK_CYC_MAX
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_srst,
    input  wire logic             i_hsel,
    input  wire logic [7:0]       i_haddr,
    input  wire logic [1:0]       i_htrans,
    input  wire logic             i_hwrite,
    input  wire logic [2:0]       i_hsize,
    input  wire logic [31:0]      i_hwdata,
    input  wire logic             i_hready,
    output logic      [31:0]      o_hrdata,
    output logic                  o_hreadyout,
    output logic                  o_hresp,
    input  wire logic             i_xact_busy,
    input  wire logic             i_pll_lock,
    input  wire lpm_pkg::lpm_wake_t i_wake,
    input  wire logic             i_reset_pin_n,
    output lpm_pkg::lpm_pwr_t     o_pwr,
    output logic      [2:0]       o_lp_state,
    output logic                  o_irq
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [8:0] sync1_reg;
    logic [8:0] sync2_reg;
    logic [8:0] prev_reg;
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            sync1_reg <= 9'h1FF;
            sync2_reg <= 9'h1FF;
            prev_reg  <= 9'h1FF;
        end else begin
            sync1_reg <= {i_reset_pin_n, i_pll_lock, i_wake};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    lpm_pkg::lpm_wake_t wk;
    lpm_pkg::lpm_wake_t wk_prev;
    wire                rst_pin_n = sync2_reg[8];
    wire                pll_lock  = sync2_reg[7];
    assign wk      = sync2_reg[6:0];
    assign wk_prev = prev_reg[6:0];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [4:0]  ctrl_reg;
    logic [2:0]  irq_sts_reg;
    logic [2:0]  irq_msk_reg;
    logic [31:0] mbox_reg;
    logic        mbox_req_reg;
    lpm_pkg::lpm_state_t state_reg;
    lpm_pkg::lpm_state_t state_next;
    logic [$clog2(LOCK_CYC+1)-1:0] lock_cnt_reg;
    logic        lock_ok_reg;
    logic        wake_by_pin_reg;

    // ------------------------------------------------------------
    // AHB-Lite decode
    // ------------------------------------------------------------
    logic        ap_wr_reg;
    logic        ap_rd_reg;
    logic [7:0]  ap_addr_reg;
    wire         ap_valid = i_hsel & i_htrans[1] & i_hready;
    wire         wr_ctrl  = ap_wr_reg & (ap_addr_reg == lpm_pkg::LPM_OFF_CTRL);
    wire         wr_msk   = ap_wr_reg & (ap_addr_reg == lpm_pkg::LPM_OFF_IRQ_MSK);
    wire         wr_mbox  = ap_wr_reg & (ap_addr_reg == lpm_pkg::LPM_OFF_MBOX);
    wire         rd_sts   = ap_valid & ~i_hwrite & (i_haddr == lpm_pkg::LPM_OFF_IRQ_STS);
    wire [2:0]   sel_mode = ctrl_reg[lpm_pkg::LPM_CTRL_MODE_LSB +: 3];
    wire         cts_pol  = ctrl_reg[lpm_pkg::LPM_CTRL_CTSP_BIT];
    wire         fw_req   = ctrl_reg[lpm_pkg::LPM_CTRL_REQ_BIT];
    wire [31:0]  rd_mux   =
        (i_haddr == lpm_pkg::LPM_OFF_CTRL)    ? {27'h0, ctrl_reg} :
        (i_haddr == lpm_pkg::LPM_OFF_STATUS)  ? {25'h0, pll_lock, o_lp_state, state_reg} :
        (i_haddr == lpm_pkg::LPM_OFF_IRQ_STS) ? {29'h0, irq_sts_reg} :
        (i_haddr == lpm_pkg::LPM_OFF_IRQ_MSK) ? {29'h0, irq_msk_reg} :
        (i_haddr == lpm_pkg::LPM_OFF_MBOX)    ? mbox_reg : 32'h0;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ap_wr_reg   <= 1'b0;
            ap_rd_reg   <= 1'b0;
            ap_addr_reg <= 8'h00;
            o_hrdata    <= 32'h0;
        end else begin
            ap_wr_reg   <= ap_valid & i_hwrite;
            ap_rd_reg   <= ap_valid & ~i_hwrite;
            ap_addr_reg <= i_haddr;
            if (ap_valid & ~i_hwrite) begin
                o_hrdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Wake detection
    // ------------------------------------------------------------
    wire line_evt = (wk.dp ^ wk_prev.dp) | (wk.dm ^ wk_prev.dm);
    wire id_evt   = wk.otg_id ^ wk_prev.otg_id;
    wire cts_evt  = wk.uart_cts == cts_pol;
    wire wake_any = line_evt | id_evt | wk.ssrx_resume | wk.vbus | cts_evt | wk.ctl0;
    wire pin_rst  = ~rst_pin_n;
    wire asleep   = (state_reg == lpm_pkg::LPM_SUSPEND) | (state_reg == lpm_pkg::LPM_LOWPOWER);
    wire enter_req = fw_req | mbox_req_reg;

    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            lpm_pkg::LPM_NORMAL: begin
                if (enter_req) begin
                    state_next = lpm_pkg::LPM_DRAIN;
                end
            end
            lpm_pkg::LPM_DRAIN: begin
                if (!i_xact_busy) begin
                    state_next = (sel_mode == 3'h1) ? lpm_pkg::LPM_SUSPEND : lpm_pkg::LPM_LOWPOWER;
                end
            end
            lpm_pkg::LPM_SUSPEND,
            lpm_pkg::LPM_LOWPOWER: begin
                if (wake_any | pin_rst) begin
                    state_next = lpm_pkg::LPM_RELOCK;
                end
            end
            lpm_pkg::LPM_RELOCK: begin
                if (lock_ok_reg) begin
                    state_next = lpm_pkg::LPM_NORMAL;
                end
            end
            default: begin
                state_next = lpm_pkg::LPM_NORMAL;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state_reg <= lpm_pkg::LPM_NORMAL;
        end else begin
            state_reg <= state_next;
        end
    end

    // Lock wait: lock must be seen for LOCK_CYC+1 cycles in a row
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            lock_cnt_reg <= '0;
            lock_ok_reg  <= 1'b0;
        end else if (state_reg != lpm_pkg::LPM_RELOCK || !pll_lock) begin
            lock_cnt_reg <= '0;
            lock_ok_reg  <= 1'b0;
        end else if (lock_cnt_reg != LOCK_CYC[$bits(lock_cnt_reg)-1:0]) begin
            lock_cnt_reg <= lock_cnt_reg + 1'b1;
        end else begin
            lock_ok_reg  <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            wake_by_pin_reg <= 1'b0;
        end else if (asleep & pin_rst) begin
            wake_by_pin_reg <= 1'b1;
        end else if (asleep & wake_any) begin
            wake_by_pin_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ctrl_reg     <= lpm_pkg::LPM_CTRL_RST;
            irq_msk_reg  <= lpm_pkg::LPM_IRQ_RST;
            mbox_reg     <= 32'h0;
            mbox_req_reg <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= i_hwdata[4:0];
            end else if (state_reg == lpm_pkg::LPM_DRAIN) begin
                ctrl_reg[lpm_pkg::LPM_CTRL_REQ_BIT] <= 1'b0;
            end
            if (wr_msk) begin
                irq_msk_reg <= i_hwdata[2:0];
            end
            if (wr_mbox) begin
                mbox_reg <= i_hwdata;
            end
            if (wr_mbox && i_hwdata == lpm_pkg::LPM_MBOX_SUSPEND) begin
                mbox_req_reg <= 1'b1;
            end else if (state_reg == lpm_pkg::LPM_DRAIN) begin
                mbox_req_reg <= 1'b0;
            end
        end
    end

    // Sticky events, set wins over read clear
    wire [2:0] irq_set = {state_reg == lpm_pkg::LPM_RELOCK && state_next == lpm_pkg::LPM_NORMAL,
                          state_reg == lpm_pkg::LPM_DRAIN && state_next != lpm_pkg::LPM_DRAIN,
                          asleep && state_next == lpm_pkg::LPM_RELOCK};
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            irq_sts_reg <= lpm_pkg::LPM_IRQ_RST;
            o_irq       <= 1'b0;
        end else begin
            irq_sts_reg <= (rd_sts ? 3'h0 : irq_sts_reg) | irq_set;
            o_irq       <= |(((rd_sts ? 3'h0 : irq_sts_reg) | irq_set) & irq_msk_reg);
        end
    end

    // ------------------------------------------------------------
    // Power outputs
    // ------------------------------------------------------------
    wire run = (state_reg == lpm_pkg::LPM_NORMAL) | (state_reg == lpm_pkg::LPM_DRAIN);
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_pwr      <= '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, pll_en: 1'b1, phy_u3: 1'b0,
                            io_hold: 1'b0, mem_retain: 1'b0, pc_hold: 1'b0};
            o_lp_state <= 3'h0;
        end else begin
            o_pwr.cpu_clk_en    <= run;
            o_pwr.periph_clk_en <= run;
            o_pwr.pll_en        <= ~asleep;
            o_pwr.phy_u3        <= asleep & (o_lp_state == 3'h1);
            o_pwr.io_hold       <= asleep;
            o_pwr.mem_retain    <= asleep;
            o_pwr.pc_hold       <= ~run & ~(state_reg == lpm_pkg::LPM_RELOCK && wake_by_pin_reg);
            if (state_reg == lpm_pkg::LPM_DRAIN && state_next != lpm_pkg::LPM_DRAIN) begin
                o_lp_state <= sel_mode;
            end else if (state_reg == lpm_pkg::LPM_RELOCK && state_next == lpm_pkg::LPM_NORMAL) begin
                o_lp_state <= 3'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence drain_done_s;
        state_reg == lpm_pkg::LPM_DRAIN && !i_xact_busy;
    endsequence

    normal_clocks_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        state_reg == lpm_pkg::LPM_NORMAL && $past(state_reg) == lpm_pkg::LPM_NORMAL
        |-> o_pwr.cpu_clk_en && o_pwr.pll_en)
        else $error("clocks off in normal mode");

    drain_wait_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        state_reg == lpm_pkg::LPM_DRAIN && i_xact_busy |=> state_reg == lpm_pkg::LPM_DRAIN)
        else $error("left drain while busy");

    enter_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        drain_done_s |=> ##1 o_pwr.io_hold && o_pwr.mem_retain)
        else $error("no hold after entry");

    phy_u3_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        o_pwr.phy_u3 |-> !o_pwr.cpu_clk_en && !o_pwr.pll_en)
        else $error("logic on during phy-on suspend");

    fw_entry_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        state_reg == lpm_pkg::LPM_NORMAL && fw_req |=> state_reg == lpm_pkg::LPM_DRAIN)
        else $error("firmware request ignored");

    mbox_entry_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        wr_mbox && i_hwdata == lpm_pkg::LPM_MBOX_SUSPEND && state_reg == lpm_pkg::LPM_NORMAL
        |=> ##1 state_reg == lpm_pkg::LPM_DRAIN)
        else $error("mailbox request ignored");

    wake_exit_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        asleep && (wake_any || pin_rst) |=> state_reg == lpm_pkg::LPM_RELOCK)
        else $error("wake event missed");

    relock_gate_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        state_reg == lpm_pkg::LPM_RELOCK && !pll_lock |=> ##1 !o_pwr.cpu_clk_en)
        else $error("clock released before lock");

    mode_code_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        drain_done_s |=> ##1 o_lp_state == $past(sel_mode, 2))
        else $error("wrong low-power code");

    sequence pin_relock_s;
        state_reg == lpm_pkg::LPM_RELOCK && wake_by_pin_reg;
    endsequence

    retain_mem_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        asleep |=> o_pwr.mem_retain && o_pwr.io_hold)
        else $error("memory not retained while asleep");

    io_release_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        state_reg == lpm_pkg::LPM_NORMAL |=> !o_pwr.io_hold)
        else $error("pins held in normal mode");

    pc_keep_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        state_reg == lpm_pkg::LPM_RELOCK && !wake_by_pin_reg |=> o_pwr.pc_hold)
        else $error("program counter released on line wake");

    pc_restart_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        pin_relock_s |=> !o_pwr.pc_hold)
        else $error("program counter kept on pin wake");

    sleep_stay_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        asleep && !wake_any && !pin_rst |=> asleep)
        else $error("left sleep without wake event");

    relock_pll_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        state_reg == lpm_pkg::LPM_RELOCK |=> o_pwr.pll_en && !o_pwr.periph_clk_en)
        else $error("pll off or clocks on during relock");

    drain_exit_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        drain_done_s |=> state_reg != lpm_pkg::LPM_DRAIN)
        else $error("stuck in drain when idle");

    phy_off_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        state_reg == lpm_pkg::LPM_LOWPOWER |=> !o_pwr.phy_u3)
        else $error("phy kept in U3 outside phy-on suspend");

endmodule

// file: bench/lpm_far_model.sv
// Far-side model: PLL lock behaviour and outstanding transaction activity
`timescale 1ns/10ps
module lpm_far_model (
    input  wire logic       i_sys_clk,
    input  wire logic       i_pll_en,
    input  wire logic [7:0] i_lock_dly,
    input  wire logic [7:0] i_busy_len,
    input  wire logic       i_busy_go,
    output logic            o_pll_lock,
    output logic            o_xact_busy
);
    logic [7:0] lock_cnt_reg = 8'h00;
    logic [7:0] busy_cnt_reg = 8'h00;
    // ------------------------------------------------------------
    // Lock after set delay, lost when PLL off; transfers run down
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!i_pll_en) begin
            lock_cnt_reg <= 8'h00;
        end else if (lock_cnt_reg < i_lock_dly) begin
            lock_cnt_reg <= lock_cnt_reg + 8'h01;
        end
        if (i_busy_go) begin
            busy_cnt_reg <= i_busy_len;
        end else if (busy_cnt_reg != 8'h00) begin
            busy_cnt_reg <= busy_cnt_reg - 8'h01;
        end
    end
    assign o_pll_lock  = i_pll_en && (lock_cnt_reg == i_lock_dly);
    assign o_xact_busy = (busy_cnt_reg != 8'h00);
endmodule

// file: bench/lpm_ctrl_tb.sv
// Self-checking testbench for the low-power mode controller
`timescale 1ns/10ps
module lpm_ctrl_tb;
    localparam int LOCK_CYC = 4;
    logic               sys_clk, srst, hsel, hwrite, hreadyout, hresp;
    logic               xact_busy, pll_lock, reset_pin_n, irq, busy_go, pol, pc;
    logic [7:0]         haddr, lock_dly, busy_len;
    logic [1:0]         htrans;
    logic [2:0]         hsize, lp_state, mode, msk;
    logic [31:0]        hwdata, hrdata, rd;
    lpm_pkg::lpm_wake_t wake, idle;
    lpm_pkg::lpm_pwr_t  pwr;
    int                 n_mismatch, n_checks, n, src;

    lpm_ctrl #(.LOCK_CYC(LOCK_CYC)) lpm_ctrl_inst (
        .i_sys_clk(sys_clk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout),
        .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp), .i_xact_busy(xact_busy),
        .i_pll_lock(pll_lock), .i_wake(wake), .i_reset_pin_n(reset_pin_n), .o_pwr(pwr),
        .o_lp_state(lp_state), .o_irq(irq));
    lpm_far_model lpm_far_model_inst (
        .i_sys_clk(sys_clk), .i_pll_en(pwr.pll_en), .i_lock_dly(lock_dly), .i_busy_len(busy_len),
        .i_busy_go(busy_go), .o_pll_lock(pll_lock), .o_xact_busy(xact_busy));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wait_rdy;
        do begin
            @(posedge sys_clk);
        end while (hreadyout !== 1'b1);
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wait_on(input int which);
        int k;
        k = 0;
        while (((which == 0) ? (lp_state === 3'h0) : (pwr.pll_en !== 1'b1)) && k < 300) begin
            @(posedge sys_clk);
            k++;
        end
    endtask

    function automatic logic [31:0] ctrl_val(input logic p, input logic [2:0] m, input logic q);
        return {27'h0, p, m, q};
    endfunction

    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #(25 * 30000);
        n_mismatch++;
        finish_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        srst = 1'b1;
        {hsel, hwrite, busy_go, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        reset_pin_n = 1'b1;
        wake = '0;
        lock_dly = 8'h00;
        busy_len = 8'h00;
        n_mismatch = 0;
        n_checks = 0;
        void'($urandom(22));
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        check(32'(pwr), 32'h70);
        check(32'({lp_state, irq}), 32'h0);
        check(32'({hresp, hreadyout}), 32'h1);
        bus(1'b0, lpm_pkg::LPM_OFF_CTRL, 32'h0);
        check(rd, 32'(lpm_pkg::LPM_CTRL_RST));
        bus(1'b1, 8'h20, $urandom);
        bus(1'b0, 8'h20, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, lpm_pkg::LPM_OFF_STATUS, 32'hFF);
        bus(1'b0, lpm_pkg::LPM_OFF_STATUS, 32'h0);
        check(32'(rd[6:0]), 32'h40);
        bus(1'b0, lpm_pkg::LPM_OFF_IRQ_STS, 32'h0);
        $display("test reset done");
        for (int r = 0; r < 12; r++) begin
            src = (r < 8) ? r : int'($urandom_range(7));
            mode = (r > 8) ? 3'(r - 7) : 3'h1;
            if (mode != 3'h1) src = 7;
            pol = 1'($urandom);
            msk = 3'($urandom);
            idle = {3'($urandom), 2'b00, ~pol, 1'b0};
            wake <= idle;
            lock_dly <= 8'($urandom_range(15));
            busy_len <= 8'($urandom_range(40, 25));
            bus(1'b1, lpm_pkg::LPM_OFF_IRQ_MSK, {29'h0, msk});
            bus(1'b1, lpm_pkg::LPM_OFF_CTRL, ctrl_val(pol, mode, 1'b0));
            @(posedge sys_clk);
            busy_go <= 1'b1;
            @(posedge sys_clk);
            busy_go <= 1'b0;
            if (r % 2 == 1) bus(1'b1, lpm_pkg::LPM_OFF_MBOX, lpm_pkg::LPM_MBOX_SUSPEND);
            else bus(1'b1, lpm_pkg::LPM_OFF_CTRL, ctrl_val(pol, mode, 1'b1));
            bus(1'b0, lpm_pkg::LPM_OFF_STATUS, 32'h0);
            check(32'({rd[2:0], lp_state}), 32'h8);
            wait_on(0);
            @(posedge sys_clk);
            check(32'(xact_busy), 32'h0);
            check(32'(lp_state), 32'(mode));
            if (mode == 3'h1) check(32'(pwr), 32'h0F);
            else check(32'(pwr[6:3]), 32'h0);
            bus(1'b0, lpm_pkg::LPM_OFF_CTRL, 32'h0);
            check(rd, ctrl_val(pol, mode, 1'b0));
            bus(1'b0, lpm_pkg::LPM_OFF_IRQ_MSK, 32'h0);
            check(rd, {29'h0, msk});
            check(32'(lp_state), 32'(mode));
            if (src == 7) reset_pin_n <= 1'b0;
            else wake <= idle ^ (7'h40 >> src);
            repeat (4) @(posedge sys_clk);
            reset_pin_n <= 1'b1;
            wait_on(1);
            check(32'(pwr.cpu_clk_en), 32'h0);
            n = 0;
            pc = pwr.pc_hold;
            while (pwr.cpu_clk_en !== 1'b1 && n < 300) begin
                pc = pwr.pc_hold;
                @(posedge sys_clk);
                n++;
            end
            check(32'(n), 32'(int'(lock_dly) + LOCK_CYC + 5));
            check(32'(pc), 32'(src != 7));
            repeat (2) @(posedge sys_clk);
            check(32'({pwr, lp_state}), 32'h380);
            check(32'(irq), 32'(msk != 3'h0));
            bus(1'b0, lpm_pkg::LPM_OFF_IRQ_STS, 32'h0);
            check(rd, 32'h7);
            bus(1'b0, lpm_pkg::LPM_OFF_IRQ_STS, 32'h0);
            check({rd[31:1], irq}, 32'h0);
            $display("test %0d done", r);
        end
        finish_test();
    end
endmodule
